// File: hdl/cxc_pkg.sv
// constants for the compare / exclusive-or / coprocessor dispatch block
// assumes a classic wishbone master on one 100 MHz clock, byte addresses
package cxc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_FIRST_OPERAND = 8'h00;
    localparam logic [7:0] REG_SECOND_OPERAND = 8'h04;
    localparam logic [7:0] REG_SHIFT_COUNT = 8'h08;
    localparam logic [7:0] REG_COMMAND = 8'h0C;
    localparam logic [7:0] REG_COPROC_FIELDS = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;
    localparam logic [7:0] REG_STATUS_WORD = 8'h18;
    localparam logic [7:0] REG_BLOCK_STATUS = 8'h1C;

    // ------------------------------------------------------------
    // command register fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_COND_LSB = 4;
    localparam int CMD_IMM_BIT = 8;
    localparam int CMD_SETF_BIT = 9;
    localparam int CMD_PLOAD_BIT = 10;
    localparam int CMD_SHREG_BIT = 11;
    localparam int CMD_SHTYPE_LSB = 12;
    localparam int CMD_EXTEND_BIT = 14;
    localparam int CMD_SHAMT_LSB = 15;
    localparam int CMD_IMM8_LSB = 20;
    localparam int CMD_ROT_LSB = 28;

    // ------------------------------------------------------------
    // coprocessor field register, status word, block status
    // ------------------------------------------------------------
    localparam int CPF_DST_LSB = 0;
    localparam int CPF_SRC1_LSB = 4;
    localparam int CPF_SRC2_LSB = 8;
    localparam int CPF_NUM_LSB = 12;
    localparam int CPF_OPC_LSB = 16;
    localparam int CPF_AUX_LSB = 20;
    localparam int PSW_LSB = 28;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    localparam int BST_BUSY_BIT = 0;
    localparam int BST_SKIP_BIT = 1;
    localparam int BST_REFUSED_BIT = 2;

    // ------------------------------------------------------------
    // reset values and shift limits
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_PSW = 4'h0;
    localparam logic [5:0] MAX_REG_SHIFT = 6'h20;

    typedef enum logic [3:0] {
        OP_COPROC = 4'h0,
        OP_NEG_CMP = 4'h1,
        OP_ARITH_CMP = 4'h2,
        OP_XOR = 4'h3
    } cxc_op_type;

    typedef enum logic [1:0] {
        SH_LSL = 2'h0,
        SH_LSR = 2'h1,
        SH_ASR = 2'h2,
        SH_ROR = 2'h3
    } cxc_shift_type;

    typedef enum logic [1:0] {
        CP_IDLE = 2'h1,
        CP_WAIT = 2'h2
    } cxc_cp_state_type;

endpackage : cxc_pkg

// File: hdl/cxc_core.sv
// execution unit: compares, exclusive or, coprocessor dispatch
// assumes wishbone master and coprocessor both on clk_i
module cxc_core
    import cxc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // coprocessor interface
    output logic cp_valid_o,
    output logic [15:0] cp_sel_o,
    output logic [3:0] cp_num_o,
    output logic [3:0] cp_opc_o,
    output logic [3:0] cp_dst_reg_o,
    output logic [3:0] cp_src1_reg_o,
    output logic [3:0] cp_src2_reg_o,
    output logic [2:0] cp_aux_o,
    input wire logic cp_ack_i
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] be);
        logic [31:0] w;
        w = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                w[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return w;
    endfunction : merge_bytes

    function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
        logic n, z, c, v, r;
        n = f[FLAG_N];
        z = f[FLAG_Z];
        c = f[FLAG_C];
        v = f[FLAG_V];
        unique case (cc)
            4'h0: r = z;
            4'h1: r = !z;
            4'h2: r = c;
            4'h3: r = !c;
            4'h4: r = n;
            4'h5: r = !n;
            4'h6: r = v;
            4'h7: r = !v;
            4'h8: r = c && !z;
            4'h9: r = !c || z;
            4'hA: r = n == v;
            4'hB: r = n != v;
            4'hC: r = !z && (n == v);
            4'hD: r = z || (n != v);
            4'hE: r = 1'b1;
            4'hF: r = 1'b0;
        endcase
        return r;
    endfunction : cond_ok

    // returns {carry, value}; amount 0 passes value and carry through
    function automatic logic [32:0] barrel(input logic [31:0] v, input logic [1:0] kind,
                                           input logic [5:0] amt, input logic cin);
        logic [32:0] t;
        logic [63:0] dbl;
        t = {cin, v};
        dbl = {v, v} >> amt[4:0];
        if (amt != 6'h00)
        begin
            unique case (kind)
                SH_LSL:
                begin
                    t = {1'b0, v} << amt;
                end
                SH_LSR:
                begin
                    t = {v, 1'b0} >> amt;
                    t = {t[0], t[32:1]};
                end
                SH_ASR:
                begin
                    t = 33'($signed({v, 1'b0}) >>> amt);
                    t = {t[0], t[32:1]};
                end
                SH_ROR:
                begin
                    t = {dbl[31], dbl[31:0]};
                end
            endcase
        end
        return t;
    endfunction : barrel

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] first_operand_ff;
    logic [31:0] second_operand_ff;
    logic [31:0] shift_count_ff;
    logic [31:0] command_ff;
    logic [31:0] cp_fields_ff;
    logic [31:0] result_ff;
    logic [3:0] psw_ff;
    logic skip_ff;
    logic refused_ff;
    logic ack_ff;
    logic [31:0] rd_data_ff;
    cxc_cp_state_type cp_state_ff;

    // ------------------------------------------------------------
    // bus slave: ack one cycle after request, data with ack
    // ------------------------------------------------------------
    logic req;
    logic wr_acc;
    logic [5:0] word_adr;
    logic [31:0] nxt_command;
    logic [31:0] rd_mux;

    assign req = cyc_i && stb_i;
    assign wr_acc = req && we_i && ack_ff;
    assign word_adr = adr_i[7:2];
    assign nxt_command = merge_bytes(command_ff, dat_i, sel_i);
    assign ack_o = ack_ff;
    assign dat_o = rd_data_ff;

    always_comb
    begin
        rd_mux = RST_WORD;
        unique case (word_adr)
            REG_FIRST_OPERAND[7:2]: rd_mux = first_operand_ff;
            REG_SECOND_OPERAND[7:2]: rd_mux = second_operand_ff;
            REG_SHIFT_COUNT[7:2]: rd_mux = shift_count_ff;
            REG_COMMAND[7:2]: rd_mux = command_ff;
            REG_COPROC_FIELDS[7:2]: rd_mux = cp_fields_ff;
            REG_RESULT[7:2]: rd_mux = result_ff;
            REG_STATUS_WORD[7:2]: rd_mux = {psw_ff, 28'h0000000};
            REG_BLOCK_STATUS[7:2]:
                rd_mux = {29'h0, refused_ff, skip_ff, cp_state_ff == CP_WAIT};
            default: rd_mux = RST_WORD;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rd_data_ff <= RST_WORD;
        end
        else
        begin
            ack_ff <= req && !ack_ff;
            rd_data_ff <= (req && !ack_ff && !we_i) ? rd_mux : RST_WORD;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_operand_ff <= RST_WORD;
            second_operand_ff <= RST_WORD;
            shift_count_ff <= RST_WORD;
            cp_fields_ff <= RST_WORD;
        end
        else if (wr_acc)
        begin
            if (word_adr == REG_FIRST_OPERAND[7:2])
                first_operand_ff <= merge_bytes(first_operand_ff, dat_i, sel_i);
            if (word_adr == REG_SECOND_OPERAND[7:2])
                second_operand_ff <= merge_bytes(second_operand_ff, dat_i, sel_i);
            if (word_adr == REG_SHIFT_COUNT[7:2])
                shift_count_ff <= merge_bytes(shift_count_ff, dat_i, sel_i);
            if (word_adr == REG_COPROC_FIELDS[7:2])
                cp_fields_ff <= merge_bytes(cp_fields_ff, dat_i, sel_i);
        end
    end

    // ------------------------------------------------------------
    // operand decode and second operand
    // ------------------------------------------------------------
    logic cmd_write;
    logic cp_busy;
    logic exec_go;
    logic cond_true;
    logic [3:0] op;
    logic is_cmp;
    logic [5:0] shift_amt;
    logic [7:0] reg_cnt;
    logic [32:0] sec_full;
    logic [31:0] sec_val;
    logic sec_carry;

    assign cmd_write = wr_acc && (word_adr == REG_COMMAND[7:2]);
    assign cp_busy = cp_state_ff == CP_WAIT;
    assign exec_go = cmd_write && !cp_busy;
    assign op = nxt_command[CMD_OP_LSB +: 4];
    assign cond_true = cond_ok(nxt_command[CMD_COND_LSB +: 4], psw_ff);
    assign is_cmp = (op == OP_NEG_CMP) || (op == OP_ARITH_CMP);
    assign reg_cnt = shift_count_ff[7:0];

    always_comb
    begin
        if (!nxt_command[CMD_SHREG_BIT])
            shift_amt = {1'b0, nxt_command[CMD_SHAMT_LSB +: 5]};
        else if (op == OP_NEG_CMP)
            shift_amt = {1'b0, reg_cnt[4:0]};
        else if (reg_cnt > 8'(MAX_REG_SHIFT))
            shift_amt = MAX_REG_SHIFT;
        else
            shift_amt = reg_cnt[5:0];
        if (nxt_command[CMD_IMM_BIT])
        begin
            // 8-bit immediate rotated right by twice the rotate field
            sec_full = barrel({24'h000000, nxt_command[CMD_IMM8_LSB +: 8]}, SH_ROR,
                              {1'b0, nxt_command[CMD_ROT_LSB +: 4], 1'b0},
                              psw_ff[FLAG_C]);
        end
        else if (nxt_command[CMD_EXTEND_BIT])
        begin
            sec_full = {second_operand_ff[0], psw_ff[FLAG_C],
                        second_operand_ff[31:1]};
        end
        else
        begin
            sec_full = barrel(second_operand_ff, nxt_command[CMD_SHTYPE_LSB +: 2],
                              shift_amt, psw_ff[FLAG_C]);
        end
    end

    assign sec_val = sec_full[31:0];
    assign sec_carry = sec_full[32];

    // ------------------------------------------------------------
    // alu and flags
    // ------------------------------------------------------------
    logic [32:0] sum;
    logic [32:0] diff;
    logic [31:0] xor_res;
    logic [31:0] alu_res;
    logic [3:0] alu_flags;
    logic [3:0] nxt_psw;
    logic cmp_ge;
    logic [31:0] psw_wr;

    assign sum = {1'b0, first_operand_ff} + {1'b0, sec_val};
    assign diff = {1'b0, first_operand_ff} + {1'b0, ~sec_val} + 33'h1;
    assign xor_res = first_operand_ff ^ sec_val;
    assign cmp_ge = first_operand_ff >= sec_val;
    assign psw_wr = merge_bytes({psw_ff, 28'h0000000}, dat_i, sel_i);

    always_comb
    begin
        alu_res = xor_res;
        alu_flags = psw_ff;
        if (op == OP_NEG_CMP)
        begin
            alu_res = sum[31:0];
            alu_flags = {sum[31], sum[31:0] == 32'h0, sum[32],
                         (first_operand_ff[31] == sec_val[31])
                         && (sum[31] != first_operand_ff[31])};
        end
        else if (op == OP_ARITH_CMP)
        begin
            alu_res = diff[31:0];
            alu_flags = {diff[31], diff[31:0] == 32'h0, diff[32],
                         (first_operand_ff[31] != sec_val[31])
                         && (diff[31] != first_operand_ff[31])};
        end
        else
        begin
            // shifter carry only, no carry chain through the bits
            alu_flags = {xor_res[31], xor_res == 32'h0, sec_carry, psw_ff[FLAG_V]};
        end
        nxt_psw = psw_ff;
        if (is_cmp && nxt_command[CMD_PLOAD_BIT])
            nxt_psw = alu_res[PSW_LSB +: 4];
        else if (is_cmp)
            nxt_psw = alu_flags;
        else if (op == OP_XOR && nxt_command[CMD_SETF_BIT])
            nxt_psw = alu_flags;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            command_ff <= RST_WORD;
            result_ff <= RST_WORD;
            psw_ff <= RST_PSW;
        end
        else if (cmd_write)
        begin
            command_ff <= nxt_command;
            if (exec_go && cond_true)
            begin
                if (op == OP_XOR)
                    result_ff <= xor_res;
                psw_ff <= nxt_psw;
            end
        end
        else if (wr_acc && word_adr == REG_STATUS_WORD[7:2])
        begin
            psw_ff <= psw_wr[PSW_LSB +: 4];
        end
    end

    // set wins over the software clear of the refused flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            skip_ff <= 1'b0;
            refused_ff <= 1'b0;
        end
        else
        begin
            if (exec_go)
                skip_ff <= !cond_true;
            if (cmd_write && cp_busy)
                refused_ff <= 1'b1;
            else if (wr_acc && word_adr == REG_BLOCK_STATUS[7:2] && sel_i[0]
                     && dat_i[BST_REFUSED_BIT])
                refused_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // coprocessor dispatch: fields only, no data words
    // ------------------------------------------------------------
    logic cp_issue;

    assign cp_issue = exec_go && cond_true && (op == OP_COPROC);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cp_state_ff <= CP_IDLE;
            cp_num_o <= 4'h0;
            cp_opc_o <= 4'h0;
            cp_dst_reg_o <= 4'h0;
            cp_src1_reg_o <= 4'h0;
            cp_src2_reg_o <= 4'h0;
            cp_aux_o <= 3'h0;
            cp_sel_o <= 16'h0000;
        end
        else
        begin
            unique case (cp_state_ff)
                CP_IDLE:
                begin
                    if (cp_issue)
                    begin
                        cp_state_ff <= CP_WAIT;
                        cp_dst_reg_o <= cp_fields_ff[CPF_DST_LSB +: 4];
                        cp_src1_reg_o <= cp_fields_ff[CPF_SRC1_LSB +: 4];
                        cp_src2_reg_o <= cp_fields_ff[CPF_SRC2_LSB +: 4];
                        cp_num_o <= cp_fields_ff[CPF_NUM_LSB +: 4];
                        cp_opc_o <= cp_fields_ff[CPF_OPC_LSB +: 4];
                        cp_aux_o <= cp_fields_ff[CPF_AUX_LSB +: 3];
                        cp_sel_o <= 16'h0001 << cp_fields_ff[CPF_NUM_LSB +: 4];
                    end
                end
                CP_WAIT:
                begin
                    // no timeout: an absent coprocessor holds this forever
                    if (cp_ack_i)
                    begin
                        cp_state_ff <= CP_IDLE;
                        cp_sel_o <= 16'h0000;
                    end
                end
            endcase
        end
    end

    assign cp_valid_o = cp_busy;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_cp_onehot: assert property (cp_valid_o |-> cp_sel_o == (16'h0001 << cp_num_o))
        else $error("coprocessor select not one-hot on its number");
    chk_cp_fields: assert property (cp_issue |=> cp_valid_o
                                    && cp_num_o == $past(cp_fields_ff[CPF_NUM_LSB +: 4])
                                    && cp_opc_o == $past(cp_fields_ff[CPF_OPC_LSB +: 4]))
        else $error("coprocessor fields not presented after dispatch");
    chk_cp_hold: assert property (cp_valid_o && !cp_ack_i |=> cp_valid_o && $stable(cp_opc_o))
        else $error("coprocessor request dropped without answer");
    chk_dispatch_flags: assert property (exec_go && op == OP_COPROC |=> $stable(psw_ff))
        else $error("coprocessor dispatch changed flags");
    chk_cond_false: assert property (exec_go && !cond_true
                                     |=> $stable(psw_ff) && $stable(result_ff) && !cp_valid_o)
        else $error("false condition changed state");
    chk_cmp_noresult: assert property (exec_go && is_cmp |=> $stable(result_ff))
        else $error("compare wrote the result register");
    chk_cmp_carry: assert property (exec_go && cond_true && op == OP_ARITH_CMP
                                    && !nxt_command[CMD_PLOAD_BIT]
                                    |=> psw_ff[FLAG_C] == $past(cmp_ge))
        else $error("compare carry is not the no-borrow bit");
    chk_cmp_always: assert property (exec_go && cond_true && is_cmp
                                     && !nxt_command[CMD_SETF_BIT] && !nxt_command[CMD_PLOAD_BIT]
                                     |=> psw_ff == $past(alu_flags))
        else $error("compare without option left flags stale");
    chk_pload: assert property (exec_go && cond_true && is_cmp && nxt_command[CMD_PLOAD_BIT]
                                |=> psw_ff == $past(alu_res[31:28]))
        else $error("status load did not copy result bits");
    chk_xor_result: assert property (exec_go && cond_true && op == OP_XOR
                                     |=> result_ff == $past(xor_res))
        else $error("xor result not written");
    chk_xor_noflags: assert property (exec_go && op == OP_XOR && !nxt_command[CMD_SETF_BIT]
                                      |=> $stable(psw_ff))
        else $error("xor changed flags without option");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    cov_cp_round: cover property (cp_issue ##[1:20] (cp_valid_o && cp_ack_i));
    cov_cmp_pload: cover property (exec_go && is_cmp && nxt_command[CMD_PLOAD_BIT]);
    cov_xor_flags: cover property (exec_go && op == OP_XOR && nxt_command[CMD_SETF_BIT]);
    cov_cond_skip: cover property (exec_go && !cond_true);

endmodule : cxc_core

// File: verification/cxc_coproc_model.sv
// coprocessor model: answers only when its own number is selected
// assumes the core's clk_i and a one-hot select from the core
module cxc_coproc_model
#(
    parameter logic [3:0] MY_NUM = 4'h0
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request side, no data lines exist
    input wire logic valid_i,
    input wire logic [15:0] sel_i,
    input wire logic [7:0] delay_i,
    // answer side
    output logic ack_o,
    output logic [7:0] seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_ff;

    // only register numbers cross, never a data word
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !(valid_i && sel_i[MY_NUM]))
        begin
            wait_ff <= 8'h00;
            ack_o <= 1'b0;
        end
        else if (!ack_o && wait_ff == delay_i)
            ack_o <= 1'b1;
        else
        begin
            ack_o <= 1'b0;
            wait_ff <= wait_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            seen_o <= 8'h00;
        else if (ack_o)
            seen_o <= seen_o + 8'h01;
    end
endmodule : cxc_coproc_model

// File: verification/compare_xor_coproc_dispatch_bench.sv
// bench: register-level tests of the execution block
// assumes coprocessors 1 and 2 are modelled on the same clock
module compare_xor_coproc_dispatch_bench import cxc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cp_valid_o, ack1, ack2;
    logic [7:0] adr_i, dly, seen1, seen2;
    logic [3:0] sel_i, cp_num_o, cp_opc_o, cp_dst_reg_o, cp_src1_reg_o, cp_src2_reg_o;
    logic [31:0] dat_i, dat_o, rd, fv;
    logic [15:0] cp_sel_o;
    logic [2:0] cp_aux_o;
    logic [31:0] sh_exp [4] = '{32'h10, 32'h0800_0000, 32'hF800_0000, 32'h1800_0000};
    int bad_count = 0;
    int checks_done = 0;

    cxc_core u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .cp_valid_o, .cp_sel_o, .cp_num_o, .cp_opc_o, .cp_dst_reg_o,
        .cp_src1_reg_o, .cp_src2_reg_o, .cp_aux_o, .cp_ack_i(ack1 | ack2));
    cxc_coproc_model #(.MY_NUM(4'h1)) u_cp1 (.clk_i, .rst_i, .valid_i(cp_valid_o),
        .sel_i(cp_sel_o), .delay_i(dly), .ack_o(ack1), .seen_o(seen1));
    cxc_coproc_model #(.MY_NUM(4'h2)) u_cp2 (.clk_i, .rst_i, .valid_i(cp_valid_o),
        .sel_i(cp_sel_o), .delay_i(dly), .ack_o(ack2), .seen_o(seen2));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // --------
    // tasks
    // --------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // bounded wait on ack; a hang ends the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : xfer

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rdchk

    task automatic run(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
        input logic [31:0] cmd);
        xfer(1'b1, REG_FIRST_OPERAND, a);
        xfer(1'b1, REG_SECOND_OPERAND, b);
        xfer(1'b1, REG_SHIFT_COUNT, c);
        xfer(1'b1, REG_COMMAND, cmd);
    endtask : run

    task automatic wait_cp(input logic lvl);
        int n;
        n = 0;
        while (cp_valid_o !== lvl && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_cp

    // fl is {shift by register, status load, set flags, immediate}
    function automatic logic [31:0] mk(input logic [3:0] op, input logic [3:0] cond,
        input logic [3:0] fl, input logic [1:0] kind, input logic [4:0] amt,
        input logic [7:0] imm8, input logic [3:0] rot);
        return {rot, imm8, amt, 1'b0, kind, fl, cond, op};
    endfunction : mk

    // --------
    // main sequence
    // --------
    initial
    begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, dly} = {4'h8, 8'h0, 4'hF, 40'hC};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("status", REG_STATUS_WORD, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        $display("test reset done");
        run(32'h5, 32'h5, 32'h0, mk(4'h2, 4'hE, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("cmp equal", REG_STATUS_WORD, 32'h6000_0000);
        run(32'h1, 32'h8000_0000, 32'h21, mk(4'h2, 4'hE, 4'h8, 2'h1, 5'h0, 8'h0, 4'h0));
        rdchk("cmp count 32", REG_STATUS_WORD, 32'h2000_0000);
        run(32'h7FFF_FFFF, 32'h2, 32'h21, mk(4'h1, 4'hE, 4'h8, 2'h1, 5'h0, 8'h0, 4'h0));
        rdchk("neg cmp", REG_STATUS_WORD, 32'h9000_0000);
        rdchk("cmp no write", REG_RESULT, 32'h0);
        run(32'h5000_0000, 32'h0, 32'h0, mk(4'h2, 4'hE, 4'h5, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("status load", REG_STATUS_WORD, 32'h5000_0000);
        run(32'h0, 32'h1, 32'h0, mk(4'h2, 4'hF, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("never flags", REG_STATUS_WORD, 32'h5000_0000);
        rdchk("never skip", REG_BLOCK_STATUS, 32'h2);
        run(32'hF0F0_1234, 32'h0, 32'h0, mk(4'h3, 4'hE, 4'h1, 2'h0, 5'h0, 8'hFF, 4'h4));
        rdchk("xor imm", REG_RESULT, 32'h0FF0_1234);
        rdchk("xor no setf", REG_STATUS_WORD, 32'h5000_0000);
        run(32'h8000_0000, 32'h0, 32'h0, mk(4'h3, 4'hE, 4'h3, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("xor setf", REG_STATUS_WORD, 32'h9000_0000);
        for (int k = 0; k < 4; k++)
        begin
            run(32'h0, 32'h8000_0001, 32'h0, mk(4'h3, 4'hE, 4'h0, k[1:0], 5'h4, 8'h0, 4'h0));
            rdchk("shift kind", REG_RESULT, sh_exp[k]);
        end
        $display("test alu done");
        for (int i = 1; i < 3; i++)
        begin
            dly <= (i == 1) ? 8'hC : 8'h0;
            fv = {9'h0, 3'h7, 4'h6, i[3:0], 4'h0, 4'h1, 4'h9};
            xfer(1'b1, REG_COPROC_FIELDS, fv);
            xfer(1'b1, REG_COMMAND, mk(4'h0, 4'hE, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
            wait_cp(1'b1);
            check("cp fields", {9'h0, cp_aux_o, cp_opc_o, cp_num_o, cp_src2_reg_o,
                cp_src1_reg_o, cp_dst_reg_o}, fv);
            check("cp select", {16'h0, cp_sel_o}, 32'h1 << i);
            if (i == 1)
            begin
                xfer(1'b1, REG_COMMAND, mk(4'h2, 4'hE, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
                xfer(1'b0, REG_BLOCK_STATUS, 32'h0);
                check("busy refused", rd & 32'h5, 32'h5);
            end
            wait_cp(1'b0);
        end
        check("cp1 acted", {24'h0, seen1}, 32'h1);
        check("cp2 acted", {24'h0, seen2}, 32'h1);
        rdchk("cp flags", REG_STATUS_WORD, 32'h9000_0000);
        xfer(1'b1, REG_COMMAND, mk(4'h0, 4'hF, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
        repeat (2) @(posedge clk_i);
        check("cp never", {31'h0, cp_valid_o}, 32'h0);
        $display("test coproc done");
        xfer(1'b1, REG_BLOCK_STATUS, 32'h4);
        rdchk("refused clear", REG_BLOCK_STATUS, 32'h2);
        xfer(1'b1, REG_STATUS_WORD, 32'h2000_0000);
        run(32'h0, 32'h3, 32'h0, mk(4'h3, 4'h2, 4'h2, 2'h0, 5'h0, 8'h0, 4'h0) | 32'h4000);
        rdchk("xor extend", REG_RESULT, 32'h8000_0001);
        rdchk("extend flags", REG_STATUS_WORD, 32'hA000_0000);
        run(32'h1, 32'h0, 32'h0, mk(4'h2, 4'h0, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("eq skipped", REG_STATUS_WORD, 32'hA000_0000);
        run(32'h1, 32'h1, 32'h0, mk(4'h2, 4'h4, 4'h0, 2'h0, 5'h0, 8'h0, 4'h0));
        rdchk("mi taken", REG_STATUS_WORD, 32'h6000_0000);
        $display("test extend done");
        tally_and_finish();
    end
endmodule : compare_xor_coproc_dispatch_bench
